//--- addr_decode.sv
`timescale 1ns/1ps
`default_nettype none
module addr_decode #(
  parameter int unsigned QUAL_CYCLES = addr_decode_pkg::QUAL_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] addr,
  input wire logic addr_valid,
  input wire logic rd_wr,
  input wire logic [7:0] wdata,
  input wire logic config_jumper,
  input wire logic [3:0] serial_irq,
  input wire logic downtime_timeout,
  input wire logic line_tick,
  input wire logic [7:0] downtime_minutes_in,
  input wire logic [7:0] downtime_seconds_in,
  input wire logic [7:0] ext_rdata,
  input wire logic line_low,
  input wire logic line_good,
  output addr_decode_pkg::sel_t sel,
  output logic rd_strobe,
  output logic wr_strobe,
  output logic [7:0] rdata,
  output logic downtime_clear,
  output logic [7:0] wdata_out,
  output logic power_failed
);
  logic cfg_two;
  logic tick_q;
  logic wr_status;
  logic rd_access;
  logic wr_access;
  logic [7:0] unit_status;
  logic pf;
  addr_decode_pkg::sel_t sel_d;

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // ----------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------
  // Counts below two leave no room between the first sample and the hit compare
  if (QUAL_CYCLES < 2)
  begin : g_qual_check
    $error("QUAL_CYCLES must be at least 2");
  end

  // Ground on the jumper picks configuration two
  assign cfg_two = ~config_jumper;
  assign rd_access = addr_valid && rd_wr;
  assign wr_access = addr_valid && !rd_wr;
  assign wr_status = sel_d.status && wr_access;

  // ----------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------
  // First match wins, so the config-two 0000-3FFF overlay is tested before the config-one map
  always_comb
  begin
    sel_d = '0;
    if (addr_valid)
    begin
      if (cfg_two && addr <= addr_decode_pkg::LOW_MEM_HI)
        sel_d.sram = 1'b1;
      else if (addr <= addr_decode_pkg::SRAM_C1_HI)
        sel_d.sram = 1'b1;
      else if (addr <= addr_decode_pkg::LOW_MEM_HI)
        sel_d.module_mem = 1'b1;
      else if (addr >= addr_decode_pkg::TOP_LO)
      begin
        sel_d.boot_rom = cfg_two;
        sel_d.module_mem = ~cfg_two;
      end
      else if (in_rng(addr, addr_decode_pkg::SRAM_HI_LO, addr_decode_pkg::SRAM_HI_HI))
        sel_d.sram = 1'b1;
      else if (cfg_two && in_rng(addr, addr_decode_pkg::MOD_MID_LO, addr_decode_pkg::MOD_MID_HI))
        sel_d.sram = 1'b1;
      else if (addr == addr_decode_pkg::DT_MIN_ADDR)
      begin
        sel_d.downtime_min = rd_wr;
        sel_d.downtime_clear = ~rd_wr;
      end
      else if (rd_wr && addr == addr_decode_pkg::DT_SEC_ADDR)
        sel_d.downtime_sec = 1'b1;
      else if (rd_wr && addr == addr_decode_pkg::RESTART_ADDR)
      begin
        sel_d.restart = 1'b1;
        sel_d.io_port = 1'b1;
      end
      else if (in_rng(addr, addr_decode_pkg::IO_LO,
                      rd_wr ? addr_decode_pkg::IO_RD_HI : addr_decode_pkg::IO_WR_HI))
        sel_d.io_port = 1'b1;
      else if (addr == addr_decode_pkg::STATUS_ADDR)
        sel_d.status = 1'b1;
      else if (in_rng(addr, addr_decode_pkg::SER_LO, addr_decode_pkg::SER_HI))
      begin
        sel_d.serial_adapter[addr[2:1]] = 1'b1;
        sel_d.serial_data = addr[0];
      end
      else if (addr == addr_decode_pkg::WPROT_ADDR)
      begin
        sel_d.write_protect = ~rd_wr;
        sel_d.module_id = rd_wr;
      end
      else if (rd_wr && addr == addr_decode_pkg::ID_LOC_ADDR)
        sel_d.module_id = 1'b1;
      else if (rd_wr && in_rng(addr, addr_decode_pkg::CLK_CNT_LO, addr_decode_pkg::CLK_CNT_HI))
        sel_d.clock_counter = 1'b1;
      else if (addr == addr_decode_pkg::CLK_VALID_A ||
               (rd_wr && addr == addr_decode_pkg::CLK_VALID_B))
        sel_d.clock_valid = 1'b1;
      else
        sel_d.unmapped = 1'b1; // Reserved space, e.g. 4000-4FFF
    end
  end

  // ----------------------------------------------------------
  // Line tick flag: set wins over the status-write clear
  // A tick lost to a clearing write would stall the software's time base
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tick_q <= 1'b0;
    else if (line_tick)
      tick_q <= 1'b1;
    else if (wr_status)
      tick_q <= 1'b0;
  end

  // ----------------------------------------------------------
  // Status byte; the reserved bit reads as zero
  // ----------------------------------------------------------
  always_comb
  begin
    unit_status = {4'h0, serial_irq};
    unit_status[addr_decode_pkg::STAT_CFG_BIT] = cfg_two;
    unit_status[addr_decode_pkg::STAT_DT_BIT] = downtime_timeout;
    unit_status[addr_decode_pkg::STAT_TICK_BIT] = tick_q;
  end

  // ----------------------------------------------------------
  // Target selects and strobes, one cycle behind the address
  // Selects are registered so every target sees a glitch-free level
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sel <= '0;
      rd_strobe <= 1'b0;
      wr_strobe <= 1'b0;
    end
    else
    begin
      sel <= sel_d;
      rd_strobe <= rd_access;
      wr_strobe <= wr_access;
    end
  end

  // ----------------------------------------------------------
  // Write path: data and the downtime clear travel with the strobe
  // Write data is passed every cycle; targets qualify it with the strobe
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      downtime_clear <= 1'b0;
      wdata_out <= 8'h00;
    end
    else
    begin
      downtime_clear <= sel_d.downtime_clear;
      wdata_out <= wdata;
    end
  end

  // ----------------------------------------------------------
  // Read data mux; unmapped reads return zero so no stale byte is seen
  // Targets decoded outside this block hand their byte over untouched
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 8'h00;
    else if (sel_d.status && rd_wr)
      rdata <= unit_status;
    else if (sel_d.downtime_min)
      rdata <= downtime_minutes_in;
    else if (sel_d.downtime_sec)
      rdata <= downtime_seconds_in;
    else if (sel_d.unmapped)
      rdata <= 8'h00;
    else
      rdata <= ext_rdata;
  end

  // ----------------------------------------------------------
  // Power qualification
  // Both directions share one timer, since failure and restoration never overlap
  // ----------------------------------------------------------
  power_qualify #(
    .QUAL_CYCLES(QUAL_CYCLES)
  ) u_pq (
    .clk(clk),
    .rstn(rstn),
    .line_low(line_low),
    .line_good(line_good),
    .power_failed(pf)
  );

  // Extra flop keeps the output straight from a register; it costs one cycle of the deadline margin
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      power_failed <= 1'b0;
    else
      power_failed <= pf;
  end
endmodule
`default_nettype wire

//--- addr_decode_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module addr_decode_assertions #(
  parameter int unsigned QUAL_CYCLES = addr_decode_pkg::QUAL_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] addr,
  input wire logic addr_valid,
  input wire logic rd_wr,
  input wire logic [7:0] wdata,
  input wire logic config_jumper,
  input wire logic [3:0] serial_irq,
  input wire logic downtime_timeout,
  input wire logic line_tick,
  input wire logic [7:0] downtime_minutes_in,
  input wire logic [7:0] downtime_seconds_in,
  input wire logic [7:0] ext_rdata,
  input wire logic line_low,
  input wire logic line_good,
  input wire addr_decode_pkg::sel_t sel,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic [7:0] rdata,
  input wire logic downtime_clear,
  input wire logic [7:0] wdata_out,
  input wire logic power_failed
);
  // ----------------------------------------
  // Decode and power checks
  // ----------------------------------------
  localparam int LIM = QUAL_CYCLES * addr_decode_pkg::QUAL_LIMIT_MS / addr_decode_pkg::QUAL_MS;
  logic [31:0] low_q;
  logic [31:0] good_q;
  logic [31:0] pk_q;
  logic [15:0] a_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Runs saturate at the deadline; the peak keeps the longest low run so a late rise is not misjudged
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) low_q <= '0;
    else if (!line_low) low_q <= '0;
    else if (low_q < LIM) low_q <= low_q + 1;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) good_q <= '0;
    else if (!line_good) good_q <= '0;
    else if (good_q < LIM) good_q <= good_q + 1;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) pk_q <= '0;
    else if (line_good) pk_q <= '0;
    else if (low_q > pk_q) pk_q <= low_q;
  always_ff @(posedge clk)
    a_q <= addr;
  sequence s_rd(a);
    addr_valid && rd_wr && addr == a;
  endsequence
  sequence s_wr(a);
    addr_valid && !rd_wr && addr == a;
  endsequence
  AST_RD: assert property (addr_valid && rd_wr |=> rd_strobe && !wr_strobe)
    else $error("read not steered");
  AST_WR: assert property (addr_valid && !rd_wr |=> wr_strobe && !rd_strobe && wdata_out == $past(wdata))
    else $error("write not steered");
  AST_STAT: assert property (s_rd(16'h5fff) |=> sel.status &&
    rdata[6:0] == {$past(downtime_timeout), !$past(config_jumper), 1'b0, $past(serial_irq)})
    else $error("status byte wrong");
  AST_SRAM: assert property (addr_valid && (addr <= 16'h0fff || !config_jumper && addr <= 16'h3fff) |=> sel.sram)
    else $error("sram not selected");
  AST_TOP: assert property (addr_valid && addr[15] |=> $past(config_jumper) ? sel.module_mem : sel.boot_rom)
    else $error("top range misrouted");
  AST_RSV: assert property (addr_valid && addr[15:12] == 4'h4 |=> sel.unmapped && rdata == 8'h00)
    else $error("unassigned range selected");
  AST_DTC: assert property (s_wr(16'h5000) |=> downtime_clear ##1 !downtime_clear || $past(addr_valid))
    else $error("downtime clear missing");
  AST_SER: assert property (addr_valid && addr[15:3] == 13'h0c00 |=>
    sel.serial_adapter == 4'h1 << a_q[2:1] && sel.serial_data == a_q[0])
    else $error("serial adapter select wrong");
  AST_FAIL_EARLY: assert property ($rose(power_failed) |-> pk_q >= QUAL_CYCLES - 2)
    else $error("failure declared early");
  AST_FAIL_LATE: assert property (low_q == LIM |-> power_failed)
    else $error("failure declared late");
  AST_RST_LATE: assert property (good_q == LIM |-> !power_failed)
    else $error("restore declared late");
  AST_RST_EARLY: assert property ($fell(power_failed) |-> $past(good_q, 2) >= QUAL_CYCLES - 1)
    else $error("restore declared early");
  AST_DTM: assert property (s_rd(16'h5000) |=> rdata == $past(downtime_minutes_in))
    else $error("downtime minutes not returned");
endmodule
bind addr_decode addr_decode_assertions #(.QUAL_CYCLES(QUAL_CYCLES)) u_chk (.clk(clk), .rstn(rstn), .addr(addr),
  .addr_valid(addr_valid), .rd_wr(rd_wr), .wdata(wdata), .config_jumper(config_jumper), .serial_irq(serial_irq),
  .downtime_timeout(downtime_timeout), .line_tick(line_tick), .downtime_minutes_in(downtime_minutes_in),
  .downtime_seconds_in(downtime_seconds_in), .ext_rdata(ext_rdata), .line_low(line_low), .line_good(line_good),
  .sel(sel), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .rdata(rdata), .downtime_clear(downtime_clear),
  .wdata_out(wdata_out), .power_failed(power_failed));
`default_nettype wire

//--- addr_decode_pkg.sv
// Summary of operation
// - Power failure declared only after low-line held continuously for 50 ms.
// - Failure qualification completes within 67 ms of low-line first asserting.
// - Power restored declared only after line-good held continuously for 50 ms.
// - Restoration qualification completes within 67 ms of line-good first asserting.
// - Jumper input high selects configuration one, low selects configuration two.
// - Config one: SRAM 0000-0FFF and 6010-6FFF, module memory 1000-3FFF and 8000-FFFF, 4000-4FFF unassigned.
// - Status 5FFF reads adapter interrupts, reserved, config, downtime timeout, line tick.
// - Status configuration bit reads 0 for config one, 1 for config two.
// - Config two decodes as config one except the internal-memory replacement ranges.
// - Config two routes 0000-3FFF and 7010-7FFF to internal SRAM; 6010-6FFF is SRAM in both configurations.
// - Config two routes 8000-FFFF to on-board boot ROM.
// - Module clock counters read at 700B-700E; valid/reset at 700A and 700F.
// - Read 5000 minutes, 500F seconds; write 5000 clears both counters.
// - Any write to status location clears the pending line tick flag; a line tick in the same cycle wins and leaves it set.
// - Each serial adapter: even address control/status, odd address transmit/receive.
package addr_decode_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned QUAL_MS = 50;
  localparam int unsigned QUAL_LIMIT_MS = 67;
  localparam int unsigned QUAL_CYCLES = (CLK_HZ / 1000) * QUAL_MS;

  localparam logic [15:0] SRAM_C1_HI = 16'h0fff;
  localparam logic [15:0] LOW_MEM_HI = 16'h3fff;
  localparam logic [15:0] RSV_LO = 16'h4000;
  localparam logic [15:0] RSV_HI = 16'h4fff;
  localparam logic [15:0] DT_MIN_ADDR = 16'h5000;
  localparam logic [15:0] IO_LO = 16'h5001;
  localparam logic [15:0] IO_RD_HI = 16'h5008;
  localparam logic [15:0] IO_WR_HI = 16'h500a;
  localparam logic [15:0] RESTART_ADDR = 16'h5004;
  localparam logic [15:0] DT_SEC_ADDR = 16'h500f;
  localparam logic [15:0] STATUS_ADDR = 16'h5fff;
  localparam logic [15:0] SER_LO = 16'h6000;
  localparam logic [15:0] SER_HI = 16'h6007;
  localparam logic [15:0] SRAM_HI_LO = 16'h6010;
  localparam logic [15:0] SRAM_HI_HI = 16'h6fff;
  localparam logic [15:0] WPROT_ADDR = 16'h7000;
  localparam logic [15:0] ID_LOC_ADDR = 16'h7001;
  localparam logic [15:0] CLK_VALID_A = 16'h700a;
  localparam logic [15:0] CLK_CNT_LO = 16'h700b;
  localparam logic [15:0] CLK_CNT_HI = 16'h700e;
  localparam logic [15:0] CLK_VALID_B = 16'h700f;
  localparam logic [15:0] MOD_MID_LO = 16'h7010;
  localparam logic [15:0] MOD_MID_HI = 16'h7fff;
  localparam logic [15:0] TOP_LO = 16'h8000;

  localparam int unsigned STAT_CFG_BIT = 5;
  localparam int unsigned STAT_DT_BIT = 6;
  localparam int unsigned STAT_TICK_BIT = 7;

  // Chip selects, one pulse-free level per target, registered
  typedef struct packed {
    logic sram;
    logic module_mem;
    logic boot_rom;
    logic downtime_min;
    logic downtime_clear;
    logic downtime_sec;
    logic io_port;
    logic restart;
    logic status;
    logic [3:0] serial_adapter;
    logic serial_data;
    logic write_protect;
    logic module_id;
    logic clock_counter;
    logic clock_valid;
    logic unmapped;
  } sel_t;

  typedef enum logic [2:0] {
    PWR_GOOD = 3'b001,
    PWR_FAIL_WAIT = 3'b010,
    PWR_FAILED = 3'b100
  } pwr_state_t;

endpackage

//--- controller_address_decode_power_qualify_tb.sv
`timescale 1ns/1ps
`default_nettype none
module controller_address_decode_power_qualify_tb;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  localparam int Q = 20;
  localparam int LIM = Q * 67 / 50;
  logic clk = 0, rstn = 0, config_jumper = 1, downtime_timeout = 0, line_tick = 0, line_low = 0, line_good = 1;
  logic [3:0] serial_irq = 4'h0;
  logic [7:0] mins = 8'h2d, secs = 8'h3b, ext = 8'h96, rdata, wdata_out, wdata;
  logic [15:0] addr;
  logic addr_valid, rd_wr, rd_strobe, wr_strobe, downtime_clear, power_failed;
  addr_decode_pkg::sel_t sel;
  int n_fail = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  host_bus_model u_host (.clk(clk), .addr(addr), .addr_valid(addr_valid), .rd_wr(rd_wr), .wdata(wdata));
  addr_decode #(.QUAL_CYCLES(Q)) u_dut (.clk(clk), .rstn(rstn), .addr(addr), .addr_valid(addr_valid),
    .rd_wr(rd_wr), .wdata(wdata), .config_jumper(config_jumper), .serial_irq(serial_irq),
    .downtime_timeout(downtime_timeout), .line_tick(line_tick), .downtime_minutes_in(mins),
    .downtime_seconds_in(secs), .ext_rdata(ext), .line_low(line_low), .line_good(line_good), .sel(sel),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .rdata(rdata), .downtime_clear(downtime_clear),
    .wdata_out(wdata_out), .power_failed(power_failed));
  task finish_test();
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task t(input logic [15:0] a, input logic r, input addr_decode_pkg::sel_t e);
    u_host.acc(a, r, 8'h5a);
    chk("sel", e, sel);
  endtask
  task pw(input logic l, input logic g, input int n, input logic e);
    line_low = l;
    line_good = g;
    repeat (n) @(posedge clk);
    #1;
    chk("power_failed", e, power_failed);
  endtask
  initial
  begin
    #10000;
    n_fail++;
    finish_test();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    rstn = 1;
    t(16'h0fff, 1, '{sram:1, default:0});
    chk("strobes", 2'b10, {rd_strobe, wr_strobe});
    t(16'h1000, 1, '{module_mem:1, default:0});
    t(16'hffff, 0, '{module_mem:1, default:0});
    chk("wdata_out", 8'h5a, wdata_out);
    t(16'h4000, 1, '{unmapped:1, default:0});
    chk("rdata", 8'h00, rdata);
    t(16'h5000, 1, '{downtime_min:1, default:0});
    chk("rdata", mins, rdata);
    t(16'h500f, 1, '{downtime_sec:1, default:0});
    chk("rdata", secs, rdata);
    u_host.acc(16'h5000, 0, 8'h00);
    chk("downtime_clear", 1, downtime_clear);
    t(16'h5004, 1, '{io_port:1, restart:1, default:0});
    t(16'h500a, 0, '{io_port:1, default:0});
    chk("strobes", 2'b01, {rd_strobe, wr_strobe});
    t(16'h7000, 0, '{write_protect:1, default:0});
    t(16'h7001, 1, '{module_id:1, default:0});
    t(16'h700a, 1, '{clock_valid:1, default:0});
    t(16'h700e, 1, '{clock_counter:1, default:0});
    t(16'h700f, 1, '{clock_valid:1, default:0});
    for (int i = 0; i < 8; i++)
    begin
      t(16'h6000 + 16'(i), 1, '{serial_adapter:4'h1 << (i / 2), serial_data:i[0], default:0});
      chk("rdata", ext, rdata);
    end
    serial_irq = 4'ha;
    downtime_timeout = 1;
    line_tick = 1;
    @(posedge clk);
    #1;
    line_tick = 0;
    t(16'h5fff, 1, '{status:1, default:0});
    chk("rdata", 8'hca, rdata);
    t(16'h5fff, 0, '{status:1, default:0});
    u_host.acc(16'h5fff, 1, 8'h00);
    chk("rdata", 8'h4a, rdata);
    line_tick = 1;
    @(posedge clk);
    #1;
    line_tick = 0;
    rstn = 0;
    #1;
    chk("rdata", 8'h00, rdata);
    chk("sel", 0, sel);
    @(posedge clk);
    #1;
    rstn = 1;
    u_host.acc(16'h5fff, 1, 8'h00);
    chk("rdata", 8'h4a, rdata);
    config_jumper = 0;
    t(16'h3fff, 1, '{sram:1, default:0});
    t(16'h6010, 1, '{sram:1, default:0});
    t(16'h7fff, 0, '{sram:1, default:0});
    t(16'h8000, 1, '{boot_rom:1, default:0});
    t(16'h5000, 1, '{downtime_min:1, default:0});
    u_host.acc(16'h5fff, 1, 8'h00);
    chk("rdata", 8'h6a, rdata);
    pw(1, 0, Q - 3, 0);
    pw(0, 0, 1, 0);
    pw(1, 0, Q - 3, 0);
    pw(1, 0, LIM - Q + 3, 1);
    pw(0, 1, Q - 3, 1);
    pw(0, 0, 1, 1);
    pw(0, 1, Q - 3, 1);
    pw(0, 1, LIM - Q + 4, 0);
    finish_test();
  end
endmodule
`default_nettype wire

//--- host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic clk,
  output logic [15:0] addr,
  output logic addr_valid,
  output logic rd_wr,
  output logic [7:0] wdata
);
  // ----------------------------------------
  // Processor side of the bus
  // ----------------------------------------
  initial
  begin
    addr = 16'h0000;
    addr_valid = 1'b0;
    rd_wr = 1'b1;
    wdata = 8'h00;
  end
  // Reserved places are reached only when a test wants to see the refusal
  task acc(input logic [15:0] a, input logic r, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd_wr = r;
    wdata = d;
    addr_valid = 1'b1;
    @(posedge clk);
    #1;
    // Released lines show the inverse so a stale value is never mistaken for a live one
    addr_valid = 1'b0;
    addr = ~a;
    rd_wr = ~r;
    wdata = ~d;
  endtask
endmodule
`default_nettype wire

//--- power_qualify.sv
`timescale 1ns/1ps
`default_nettype none
module power_qualify #(
  parameter int unsigned QUAL_CYCLES = addr_decode_pkg::QUAL_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic line_low,
  input wire logic line_good,
  output logic power_failed
);
  localparam int unsigned CW = $clog2(QUAL_CYCLES + 1);

  if (QUAL_CYCLES < 2)
  begin : g_qual_check
    $error("QUAL_CYCLES too small");
  end

  addr_decode_pkg::pwr_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic hit;
  assign hit = (cnt_q == CW'(QUAL_CYCLES - 1));

  // ----------------------------------------------------------
  // Qualification timer: any dropout of the watched level restarts it
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= addr_decode_pkg::PWR_GOOD;
      cnt_q <= '0;
      power_failed <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        addr_decode_pkg::PWR_GOOD:
        begin
          cnt_q <= '0;
          if (line_low)
            state_q <= addr_decode_pkg::PWR_FAIL_WAIT;
        end
        addr_decode_pkg::PWR_FAIL_WAIT:
        begin
          if (!line_low)
          begin
            state_q <= addr_decode_pkg::PWR_GOOD;
            cnt_q <= '0;
          end
          else if (hit)
          begin
            state_q <= addr_decode_pkg::PWR_FAILED;
            power_failed <= 1'b1;
            cnt_q <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        addr_decode_pkg::PWR_FAILED:
        begin
          if (!line_good)
            cnt_q <= '0;
          else if (hit)
          begin
            state_q <= addr_decode_pkg::PWR_GOOD;
            power_failed <= 1'b0;
            cnt_q <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire
